// File: rtl/adcdc_top.sv
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module adcdc_top
  import adcdc_pkg::*;
(
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // conversion core
  input wire adcdc_result_type res_i,
  // interrupts
  output logic cmp_irq_o,
  output logic int_o
);
  logic [7:0] cfg_reg;
  logic flag_reg;
  logic [5:0] id_reg;
  logic [15:0] diff_reg;
  logic [31:0] limit_reg;
  logic [1:0] mode_reg;
  logic ist_reg;
  logic imask_reg;
  logic ack_reg;
  logic err_reg;
  logic [31:0] dat_reg;
  logic irq_reg;
  logic int_reg;

  wire req = cyc_i & stb_i & ~ack_reg & ~err_reg;
  wire sel_ctrl = adr_i == ADCDC_CTRL_OFS;
  wire sel_lim = adr_i == ADCDC_LIMIT_OFS;
  wire sel_mode = adr_i == ADCDC_MODE_OFS;
  wire sel_ist = adr_i == ADCDC_ISTAT_OFS;
  wire sel_imsk = adr_i == ADCDC_IMASK_OFS;
  wire mapped = sel_ctrl | sel_lim | sel_mode | sel_ist | sel_imsk;
  wire wr = req & we_i & mapped;
  wire rd = req & ~we_i & mapped;
  wire wr_ctrl = wr & sel_ctrl & sel_i[0];
  wire en_next = wr_ctrl ? dat_i[ADCDC_EN_BIT] : cfg_reg[ADCDC_EN_BIT];
  wire en_off = wr_ctrl & ~dat_i[ADCDC_EN_BIT];
  wire rd_id = rd & sel_ctrl;
  wire sense = mode_reg[0];
  wire [15:0] lo = limit_reg[15:0];
  wire [15:0] hi = limit_reg[31:16];
  wire fraction_format = mode_reg[1];

  function automatic logic ge16(input logic [15:0] a, input logic [15:0] b, input logic sgn);
    ge16 = sgn ? ($signed(a) >= $signed(b)) : (a >= b);
  endfunction

  // fractional results are signed, integer ones compared unsigned
  wire [15:0] d = res_i.data;
  wire id_ok = sense ? (res_i.id <= ADCDC_SENSE_MAX_ID)
                     : (res_i.id <= ADCDC_NORMAL_MAX_ID);
  wire c_btw = cfg_reg[4] & ge16(d, lo, fraction_format) & ge16(hi, d, fraction_format);
  wire c_hihi = cfg_reg[3] & ge16(d, hi, fraction_format);
  wire c_hilo = cfg_reg[2] & ~ge16(d, hi, fraction_format);
  wire c_lohi = cfg_reg[1] & ge16(d, lo, fraction_format);
  wire c_lolo = cfg_reg[0] & ~ge16(d, lo, fraction_format);
  wire hit = res_i.valid & cfg_reg[ADCDC_EN_BIT] & id_ok
             & (c_btw | c_hihi | c_hilo | c_lohi | c_lolo);
  wire [15:0] diff = 16'(res_i.pos - res_i.neg);
  // a new hit beats a read clear; disable beats both
  wire flag_next = en_off ? 1'b0 : (hit ? 1'b1 : (rd_id ? 1'b0 : flag_reg));
  wire irq_next = flag_next & (wr_ctrl ? dat_i[ADCDC_GIE_BIT] : cfg_reg[ADCDC_GIE_BIT]);
  wire ev = hit & ~flag_reg;
  wire ist_next = ev | (ist_reg & ~(wr & sel_ist & sel_i[0] & dat_i[0]));
  wire [31:0] ctrl_word = {diff_reg, 2'b00, id_reg, cfg_reg[7:6], flag_reg, cfg_reg[4:0]};
  wire [31:0] rd_mux = sel_ctrl ? ctrl_word :
                       sel_lim ? limit_reg :
                       sel_mode ? {30'h0, mode_reg} :
                       sel_ist ? {31'h0, ist_reg} : {31'h0, imask_reg};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= ADCDC_RESET_WORD[7:0];
      flag_reg <= 1'b0;
      id_reg <= 6'h00;
      diff_reg <= 16'h0000;
      limit_reg <= ADCDC_RESET_WORD;
      mode_reg <= 2'h0;
      ist_reg <= 1'b0;
      imask_reg <= 1'b0;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
      int_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        cfg_reg <= {en_next, dat_i[ADCDC_GIE_BIT], 1'b0, dat_i[4:0]};
      end
      if (wr & sel_lim) begin
        limit_reg <= dat_i;
      end
      if (wr & sel_mode & sel_i[0]) begin
        mode_reg <= dat_i[1:0];
      end
      if (wr & sel_imsk & sel_i[0]) begin
        imask_reg <= dat_i[0];
      end
      flag_reg <= flag_next;
      if (hit) begin
        id_reg <= res_i.id;
        if (sense & cfg_reg[ADCDC_GIE_BIT]) begin
          diff_reg <= diff;
        end
      end
      ist_reg <= ist_next;
      irq_reg <= irq_next;
      int_reg <= ist_next & imask_reg;
      ack_reg <= req & mapped;
      err_reg <= req & ~mapped;
      dat_reg <= rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign dat_o = dat_reg;
  assign ack_o = ack_reg;
  assign err_o = err_reg;
  assign cmp_irq_o = irq_reg;
  assign int_o = int_reg;

  // bus side: one registered answer per taken request
  sequence s_taken;
    req && mapped;
  endsequence
  sequence s_refused;
    req && !mapped;
  endsequence
  sequence s_hit;
    hit && !en_off;
  endsequence
  sequence s_read_clear;
    rd_id && !hit;
  endsequence
  sequence s_sense_capture;
    hit && sense && cfg_reg[ADCDC_GIE_BIT];
  endsequence
  // a result that may be compared at all
  sequence s_eval;
    res_i.valid && cfg_reg[ADCDC_EN_BIT] && id_ok;
  endsequence

  AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    s_taken |=> ack_o && !err_o)
    else $error("mapped request not acknowledged");
  AST_ERR_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    s_refused |=> err_o && !ack_o)
    else $error("unmapped request not refused");
  AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_ERR_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    err_o |=> !err_o)
    else $error("err longer than one cycle");
  AST_ANSWER_EXCL: assert property (@(posedge clk_i) disable iff (rst_i)
    !(ack_o && err_o))
    else $error("ack and err together");
  AST_NO_SPURIOUS: assert property (@(posedge clk_i) disable iff (rst_i)
    !(cyc_i && stb_i) |=> !ack_o && !err_o)
    else $error("answer without request");
  AST_RDATA_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
    !ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  AST_RDATA_CTRL: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && sel_ctrl |=> dat_o == $past(ctrl_word))
    else $error("control word not returned");
  AST_GAP_BUS: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && sel_ctrl |=> dat_o[15:14] == 2'b00)
    else $error("gap bits read as one");
  AST_WR_CFG: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl |=> cfg_reg[4:0] == $past(dat_i[4:0]))
    else $error("condition bits not written");
  AST_WR_GIE: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl |=> cfg_reg[ADCDC_GIE_BIT] == $past(dat_i[ADCDC_GIE_BIT]))
    else $error("irq enable not written");
  AST_WR_EN: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl |=> cfg_reg[ADCDC_EN_BIT] == $past(dat_i[ADCDC_EN_BIT]))
    else $error("enable not written");
  AST_WR_LIM: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && sel_lim |=> limit_reg == $past(dat_i))
    else $error("limits not written");
  AST_NO_ERR_EFFECT: assert property (@(posedge clk_i) disable iff (rst_i)
    s_refused |=> $stable(cfg_reg) && $stable(limit_reg) && $stable(mode_reg))
    else $error("refused request changed a register");

  AST_HIT_SETS: assert property (@(posedge clk_i) disable iff (rst_i)
    s_hit |=> flag_reg)
    else $error("hit did not set flag");
  AST_DISABLE_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    en_off |=> !flag_reg)
    else $error("disable did not clear flag");
  AST_READ_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    s_read_clear |=> !flag_reg)
    else $error("read did not clear flag");
  AST_NO_EVAL_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    !cfg_reg[ADCDC_EN_BIT] |-> !hit)
    else $error("disabled comparator evaluated");
  AST_FLAG_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    !cfg_reg[ADCDC_EN_BIT] |-> !flag_reg)
    else $error("flag set while disabled");
  AST_FLAG_RISE: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(flag_reg) |-> $past(hit))
    else $error("flag set without hit");
  AST_FLAG_FALL: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(flag_reg) |-> $past(en_off) || $past(rd_id))
    else $error("flag cleared without cause");
  AST_FLAG_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    flag_reg && !en_off && !rd_id |=> flag_reg)
    else $error("flag lost");
  AST_NO_HIT_INVALID: assert property (@(posedge clk_i) disable iff (rst_i)
    !res_i.valid |-> !hit)
    else $error("hit without result");
  AST_NO_HIT_NOCOND: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_reg[4:0] == 5'h00 |-> !hit)
    else $error("hit with no condition enabled");

  AST_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
    res_i.valid && !sense && res_i.id > ADCDC_NORMAL_MAX_ID |-> !hit)
    else $error("out-of-range input compared");
  AST_SENSE_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
    res_i.valid && sense && res_i.id > ADCDC_SENSE_MAX_ID |-> !hit)
    else $error("reserved input compared");
  AST_ID_CODE: assert property (@(posedge clk_i) disable iff (rst_i)
    id_reg <= ADCDC_SENSE_MAX_ID)
    else $error("reserved id recorded");
  AST_ID_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    hit |=> id_reg == $past(res_i.id))
    else $error("id not loaded");
  AST_ID_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !hit |=> $stable(id_reg))
    else $error("id changed without event");

  AST_DIFF: assert property (@(posedge clk_i) disable iff (rst_i)
    s_sense_capture |=> diff_reg == $past(diff))
    else $error("difference not captured");
  AST_DIFF_SUM: assert property (@(posedge clk_i) disable iff (rst_i)
    s_sense_capture |=> 16'(diff_reg + $past(res_i.neg)) == $past(res_i.pos))
    else $error("difference is not positive minus negative");
  AST_DIFF_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !(hit && sense && cfg_reg[ADCDC_GIE_BIT]) |=> $stable(diff_reg))
    else $error("difference changed without interrupt");

  AST_BTW: assert property (@(posedge clk_i) disable iff (rst_i)
    s_eval ##0 (cfg_reg[4] && !fraction_format && d >= lo && d <= hi) |-> hit)
    else $error("between missed");
  AST_BTW_SGN: assert property (@(posedge clk_i) disable iff (rst_i)
    s_eval ##0 (cfg_reg[4] && fraction_format && $signed(d) >= $signed(lo)
      && $signed(d) <= $signed(hi)) |-> hit)
    else $error("signed between missed");
  AST_HIHI: assert property (@(posedge clk_i) disable iff (rst_i)
    s_eval ##0 (cfg_reg[3] && !fraction_format && d >= hi) |-> hit)
    else $error("above high missed");
  AST_HILO: assert property (@(posedge clk_i) disable iff (rst_i)
    s_eval ##0 (cfg_reg[2] && !fraction_format && d < hi) |-> hit)
    else $error("below high missed");
  AST_LOHI: assert property (@(posedge clk_i) disable iff (rst_i)
    s_eval ##0 (cfg_reg[1] && !fraction_format && d >= lo) |-> hit)
    else $error("above low missed");
  AST_LOLO: assert property (@(posedge clk_i) disable iff (rst_i)
    s_eval ##0 (cfg_reg[0] && !fraction_format && d < lo) |-> hit)
    else $error("below low missed");

  AST_IRQ_AND: assert property (@(posedge clk_i) disable iff (rst_i)
    cmp_irq_o == (flag_reg && cfg_reg[ADCDC_GIE_BIT]))
    else $error("irq mismatch");
  AST_IRQ_REG: assert property (@(posedge clk_i) disable iff (rst_i)
    !flag_reg |-> !cmp_irq_o)
    else $error("irq without flag");
  AST_IRQ_GIE_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    !cfg_reg[ADCDC_GIE_BIT] |-> !cmp_irq_o)
    else $error("irq while globally disabled");
  AST_IRQ_FOLLOW: assert property (@(posedge clk_i) disable iff (rst_i)
    s_hit ##0 (!wr_ctrl && cfg_reg[ADCDC_GIE_BIT]) |=> cmp_irq_o)
    else $error("irq not raised on event");
  AST_IRQ_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    cmp_irq_o && !en_off && !rd_id && !wr_ctrl |=> cmp_irq_o)
    else $error("irq dropped before flag cleared");

  AST_IST_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    hit && !flag_reg |=> ist_reg)
    else $error("status event not recorded");
  AST_IST_W1C: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && sel_ist && sel_i[0] && dat_i[0] && !hit |=> !ist_reg)
    else $error("status not cleared by one");
  AST_IST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    ist_reg && !(wr && sel_ist) |=> ist_reg)
    else $error("status lost");
  AST_INT_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
    int_o |-> ist_reg)
    else $error("interrupt without status");
  AST_INT_MASK: assert property (@(posedge clk_i) disable iff (rst_i)
    !imask_reg |=> !int_o)
    else $error("masked interrupt raised");

  AST_GAP: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_word[15:14] == 2'b00)
    else $error("gap bits set");
endmodule
`default_nettype wire

// File: shared/adcdc_pkg.sv
// Functional notes
// - results are compared only while the enable bit is set, and writing it to zero clears the event flag.
// - with the global interrupt enable set an interrupt follows the event flag, with it clear none is raised on cmp_irq_o.
// - hardware sets the read-only event flag when any enabled condition is true for a result.
// - a bus read of the control word, which holds the input id field, clears the event flag.
// - on an event the 6-bit input id field loads the monitored input number; codes 45 to 63 are reserved.
// - in normal mode only inputs 0 to 31 are compared; in sensing mode inputs up to 44 are accepted.
// - in sensing mode the 16-bit difference positive minus negative is captured on each hit while the global interrupt enable is set.
// - the captured difference is signed and is stored as computed, whatever the fraction format setting.
// - the between condition flags results with low limit <= result <= high limit.
// - control bits 15 to 14 read as zero.
package adcdc_pkg;
  localparam logic [7:0] ADCDC_CTRL_OFS = 8'h00;
  localparam logic [7:0] ADCDC_LIMIT_OFS = 8'h04;
  localparam logic [7:0] ADCDC_MODE_OFS = 8'h08;
  localparam logic [7:0] ADCDC_ISTAT_OFS = 8'h0c;
  localparam logic [7:0] ADCDC_IMASK_OFS = 8'h10;
  localparam int ADCDC_EN_BIT = 7;
  localparam int ADCDC_GIE_BIT = 6;
  localparam int ADCDC_FLAG_BIT = 5;
  localparam int ADCDC_ID_LSB = 8;
  localparam int ADCDC_DIFF_LSB = 16;
  localparam logic [5:0] ADCDC_NORMAL_MAX_ID = 6'h1f;
  localparam logic [5:0] ADCDC_SENSE_MAX_ID = 6'h2c;
  localparam logic [31:0] ADCDC_RESET_WORD = 32'h0000_0000;
  typedef struct packed {
    logic valid;
    logic [5:0] id;
    logic [15:0] data;
    logic [15:0] pos;
    logic [15:0] neg;
  } adcdc_result_type;
endpackage

// File: verification/adcdc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcdc_core_model
  import adcdc_pkg::*;
(
  // system
  input wire logic clk_i,
  // results
  output var adcdc_result_type res_o
);
  initial res_o = '0;
  // idle fields inverted so a stale result never looks current
  task automatic send(input logic [5:0] id, input logic [15:0] d, input logic [15:0] p,
      input logic [15:0] n);
    @(posedge clk_i);
    res_o <= '{1'b1, id, d, p, n};
    @(posedge clk_i);
    res_o <= '{1'b0, ~id, ~d, ~p, ~n};
  endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import adcdc_pkg::*;
;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, last_err;
  logic [7:0] adr = '0;
  logic [31:0] wdat = '0, rd, dat_o;
  logic ack_o, err_o, cmp_irq_o, int_o;
  logic [15:0] hit_d [4] = '{16'h00ff, 16'h0100, 16'h01ff, 16'h0200};
  adcdc_result_type res;
  int err_total = 0, compares = 0;
  always #12.5 clk_i = ~clk_i;
  adcdc_core_model u_core(.clk_i(clk_i), .res_o(res));
  adcdc_top u_dut(.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .res_i(res), .cmp_irq_o(cmp_irq_o), .int_o(int_o));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1 && err_o !== 1'b1);
    rd = dat_o;
    last_err = err_o;
    cyc <= 0;
    stb <= 0;
  endtask
  // flag and irq are registered, so allow two edges after the result
  task automatic ev(input logic [5:0] id, input logic [15:0] d, input logic [15:0] p,
      input logic [15:0] n);
    u_core.send(id, d, p, n);
    repeat (2) @(posedge clk_i);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    wb(0, ADCDC_CTRL_OFS, 0);
    chk("ctrl_rst", rd, ADCDC_RESET_WORD);
    wb(1, ADCDC_LIMIT_OFS, 32'h0200_0100);
    // miss value of one condition is the hit value of its partner
    for (int k = 0; k < 4; k++) begin
      wb(1, ADCDC_CTRL_OFS, 32'h80 | (32'h1 << k));
      ev(6'h03, hit_d[k], 0, 0);
      wb(0, ADCDC_CTRL_OFS, 0);
      chk("cond_hit", rd[5], 1);
      ev(6'h03, hit_d[k ^ 1], 0, 0);
      wb(0, ADCDC_CTRL_OFS, 0);
      chk("cond_miss", rd[5], 0);
    end
    wb(1, ADCDC_CTRL_OFS, 32'hd0);
    ev(6'h1f, 16'h0200, 0, 0);
    chk("irq_set", cmp_irq_o, 1);
    wb(0, ADCDC_CTRL_OFS, 0);
    chk("ctrl_id", rd, 32'h0000_1ff0);
    repeat (2) @(posedge clk_i);
    chk("irq_clr", cmp_irq_o, 0);
    ev(6'h20, 16'h0150, 0, 0);
    chk("id_norm", cmp_irq_o, 0);
    ev(6'h02, 16'h0201, 0, 0);
    chk("btw_out", cmp_irq_o, 0);
    wb(1, ADCDC_MODE_OFS, 1);
    ev(6'h2c, 16'h0150, 16'h0010, 16'h0030);
    wb(0, ADCDC_CTRL_OFS, 0);
    chk("diff", rd, 32'hffe0_2cf0);
    wb(1, ADCDC_CTRL_OFS, 32'h90);
    ev(6'h01, 16'h0150, 0, 0);
    chk("gie_off", cmp_irq_o, 0);
    chk("int_mask", int_o, 0);
    wb(1, ADCDC_IMASK_OFS, 1);
    repeat (2) @(posedge clk_i);
    chk("int_on", int_o, 1);
    wb(1, ADCDC_CTRL_OFS, 32'h10);
    ev(6'h01, 16'h0150, 0, 0);
    wb(0, ADCDC_CTRL_OFS, 0);
    chk("dis_flag", rd[5], 0);
    wb(1, ADCDC_ISTAT_OFS, 1);
    repeat (2) @(posedge clk_i);
    chk("int_w1c", int_o, 0);
    // signed compare: low limit -256, high limit 256
    wb(1, ADCDC_MODE_OFS, 2);
    wb(1, ADCDC_LIMIT_OFS, 32'h0100_ff00);
    wb(1, ADCDC_CTRL_OFS, 32'hd0);
    ev(6'h05, 16'hfff0, 0, 0);
    chk("sgn_btw", cmp_irq_o, 1);
    chk("int_ev", int_o, 1);
    wb(0, ADCDC_CTRL_OFS, 0);
    chk("sgn_id", rd, 32'hffe0_05f0);
    ev(6'h05, 16'h8000, 0, 0);
    chk("sgn_out", cmp_irq_o, 0);
    wb(0, 8'h40, 0);
    chk("unmapped", last_err, 1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
